/* File: inc/scfe_pkg.sv */
// Operation
// [RULE_01] 4 KB sectors on 0x1000 boundaries
// [RULE_02] Sixteen sectors form one 64 KB block
// [RULE_03] Unknown opcode: standby, output off until select
// [RULE_04] Known opcode: active until select rises
// [RULE_05] Sample on clock rise, shift on fall
// [RULE_06] Read commands stream data until deselect
// [RULE_07] Write-type commands must end on byte boundary
// [RULE_08] Array access ignored while engine busy
// [RULE_09] Power-up reset puts command logic in standby
// [RULE_10] Content changes need write latch set first
// [RULE_11] Write latch clears after changing commands
// [RULE_12] Sleeping: only wake or signature read accepted
// [RULE_13] Protect level bits select protected blocks
// [RULE_14] Protect pin locks protect and guard bits
// [RULE_15] Pause starts on pause low, clock low
// [RULE_16] Pause ends on pause high, clock low
// [RULE_17] Paused: output off, clock and input ignored
// [RULE_18] Pause never stops internal write engine
// [RULE_19] Deselect during pause resets interface logic
// [RULE_20] Host checks status before each command
// [RULE_21] Program or erase into protected area ignored
package scfe_pkg;
	localparam int ADDR_W = 19;
	localparam int SECT_LSB = 12;
	localparam int BLK_LSB = 16;
	localparam int BLK_W = ADDR_W - BLK_LSB;
	localparam logic [BLK_W-1:0] BLK_TOP = 3'h3;
	localparam logic [BLK_W-1:0] BLK_MID = 3'h2;
	localparam logic [1:0] PL_NONE = 2'h0;
	localparam logic [1:0] PL_ONE = 2'h1;
	localparam logic [1:0] PL_TWO = 2'h2;
	localparam logic [1:0] PL_ALL = 2'h3;
	localparam logic [7:0] OP_UNLOCK = 8'h06;
	localparam logic [7:0] OP_LOCK = 8'h04;
	localparam logic [7:0] OP_STWR = 8'h01;
	localparam logic [7:0] OP_IDENT = 8'h9f;
	localparam logic [7:0] OP_STRD = 8'h05;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_PARAM = 8'h5a;
	localparam logic [7:0] OP_SIG = 8'hab;
	localparam logic [7:0] OP_MAKER = 8'h90;
	localparam logic [7:0] OP_DUAL = 8'h3b;
	localparam logic [7:0] OP_SWIPE = 8'h20;
	localparam logic [7:0] OP_BWIPE_A = 8'h52;
	localparam logic [7:0] OP_BWIPE_B = 8'hd8;
	localparam logic [7:0] OP_CWIPE_A = 8'h60;
	localparam logic [7:0] OP_CWIPE_B = 8'hc7;
	localparam logic [7:0] OP_PAGE = 8'h02;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam int SB_BUSY = 0;
	localparam int SB_WEL = 1;
	localparam int SB_LO = 2;
	localparam int SB_HI = 3;
	localparam int SB_GUARD = 7;
	localparam logic [7:0] ST_WR_MASK = 8'h8c;
	localparam logic [7:0] ST_RST = 8'h00;
	localparam logic [2:0] BIT_ZERO = 3'h0;
	localparam logic [2:0] BIT_ONE = 3'h1;
	localparam logic [2:0] BIT_TWO = 3'h2;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] NB_ZERO = 3'h0;
	localparam logic [2:0] NB_ONE = 3'h1;
	localparam logic [2:0] NB_STWR = 3'h2;
	localparam logic [2:0] ADDR_LAST = 3'h3;
	localparam logic [2:0] NB_ADDR = 3'h4;
	localparam logic [2:0] NB_PAGE = 3'h5;
	localparam logic [2:0] NB_MAX = 3'h7;

	typedef enum logic [4:0] {
		CK_NONE, CK_UNLOCK, CK_LOCK, CK_STWR, CK_STRD, CK_IDENT, CK_READ,
		CK_FAST, CK_DUAL, CK_PARAM, CK_SIG, CK_MAKER, CK_PAGE, CK_SWIPE,
		CK_BWIPE, CK_CWIPE, CK_SLEEP
	} scfe_kind_t;
	typedef enum logic [2:0] {
		SS_IDLE, SS_CMD, SS_ADDR, SS_DUMMY, SS_IN, SS_OUT, SS_IGNORE
	} scfe_state_t;
	typedef struct packed {
		scfe_kind_t kind;
		logic addr;
		logic dummy;
		logic out;
		logic dual;
	} scfe_info_t;
	typedef struct packed {
		scfe_kind_t kind;
		logic [ADDR_W-1:0] addr;
	} scfe_op_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic si;
		logic hold_n;
		logic wp_n;
	} scfe_pins_t;

	function automatic scfe_info_t cmd_decode(input logic [7:0] op);
		scfe_info_t i;
		i = '{CK_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
		case (op)
			OP_UNLOCK: i.kind = CK_UNLOCK;
			OP_LOCK: i.kind = CK_LOCK;
			OP_STWR: i.kind = CK_STWR;
			OP_SLEEP: i.kind = CK_SLEEP;
			OP_CWIPE_A, OP_CWIPE_B: i.kind = CK_CWIPE;
			OP_STRD: i = '{CK_STRD, 1'b0, 1'b0, 1'b1, 1'b0};
			OP_IDENT: i = '{CK_IDENT, 1'b0, 1'b0, 1'b1, 1'b0};
			OP_READ: i = '{CK_READ, 1'b1, 1'b0, 1'b1, 1'b0};
			OP_FAST: i = '{CK_FAST, 1'b1, 1'b1, 1'b1, 1'b0};
			OP_DUAL: i = '{CK_DUAL, 1'b1, 1'b1, 1'b1, 1'b1};
			OP_PARAM: i = '{CK_PARAM, 1'b1, 1'b1, 1'b1, 1'b0};
			OP_SIG: i = '{CK_SIG, 1'b1, 1'b0, 1'b1, 1'b0};
			OP_MAKER: i = '{CK_MAKER, 1'b1, 1'b0, 1'b1, 1'b0};
			OP_PAGE: i = '{CK_PAGE, 1'b1, 1'b0, 1'b0, 1'b0};
			OP_SWIPE: i = '{CK_SWIPE, 1'b1, 1'b0, 1'b0, 1'b0};
			OP_BWIPE_A, OP_BWIPE_B: i = '{CK_BWIPE, 1'b1, 1'b0, 1'b0, 1'b0};
			default: i.kind = CK_NONE;
		endcase
		return i;
	endfunction

	function automatic logic is_array(input scfe_kind_t k);
		return k inside {CK_READ, CK_FAST, CK_DUAL, CK_PAGE, CK_SWIPE,
			CK_BWIPE, CK_CWIPE, CK_STWR};
	endfunction

	function automatic logic is_change(input scfe_kind_t k);
		return k inside {CK_STWR, CK_PAGE, CK_SWIPE, CK_BWIPE, CK_CWIPE};
	endfunction

	function automatic logic prot_hit(input logic [ADDR_W-1:0] a,
		input logic [1:0] lvl);
		logic [BLK_W-1:0] blk;
		blk = a[ADDR_W-1:BLK_LSB]; // RULE_02
		case (lvl) // RULE_13
			PL_ONE: return blk == BLK_TOP;
			PL_TWO: return blk == BLK_TOP || blk == BLK_MID;
			PL_ALL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
		input int lsb);
		logic [ADDR_W-1:0] m;
		m = {ADDR_W{1'b1}} << lsb;
		return a & m;
	endfunction
endpackage

/* File: design/scfe_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module scfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Wraps by compare so any depth works, not only powers of two
	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready_o = cnt_q != FULL;
	assign push = in_valid_i & in_ready_o;
	// Output slot is a register so the consumer sees flop outputs
	assign pop = (cnt_q != '0) & (~out_valid_o | out_ready_i);

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			if (push) begin
				wr_q <= ptr_next(wr_q);
			end
			if (pop) begin
				out_data_o <= mem_q[rd_q];
				rd_q <= ptr_next(rd_q);
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CNT_ONE;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CNT_ONE;
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/scfe_front.sv */
`timescale 1ns/1ps
`default_nettype none
module scfe_front
	import scfe_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	output logic si_o,
	output logic si_oe_o,
	output logic so_o,
	output logic so_oe_o,
	input wire logic busy_i,
	output logic op_valid_o,
	output var scfe_op_t op_o,
	output logic rd_req_o,
	output var scfe_op_t rd_o,
	input wire logic [7:0] rd_byte_i,
	output logic pg_valid_o,
	output logic [7:0] pg_data_o,
	input wire logic pg_ready_i,
	output logic pg_overrun_o,
	output logic [7:0] status_o,
	output logic write_latch_flag_o,
	output logic sleep_o
);
	scfe_pins_t meta_q;
	scfe_pins_t pin_q;
	scfe_pins_t prev_q;
	scfe_state_t state_q;
	scfe_info_t info_q;
	scfe_info_t ci;
	scfe_op_t op_q;
	scfe_op_t rd_q;
	logic [2:0] bit_cnt_q;
	logic [2:0] byte_cnt_q;
	logic [7:0] shin_q;
	logic [ADDR_W-1:0] addr_q;
	logic hold_q;
	logic wel_q;
	logic sleep_q;
	logic [7:0] st_q;
	logic op_valid_q;
	logic flush_q;
	logic overrun_q;
	logic [7:0] sh_q;
	logic [2:0] obit_q;
	logic so_q;
	logic sio0_q;
	logic so_oe_q;
	logic si_oe_q;
	logic rd_req_q;
	logic in_out_q;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic byte_done;
	logic [7:0] nb;
	logic [7:0] stat_byte;
	logic [7:0] src_byte;
	logic [1:0] level;
	logic pin_guard;
	logic len_ok;
	logic blocked;
	logic go;
	logic push;
	logic fifo_rdy;

	function automatic logic [7:0] out_shift(input logic [7:0] v,
		input logic dual);
		return dual ? {v[5:0], 2'h0} : {v[6:0], 1'h0};
	endfunction

	// Pins are asynchronous to mclk: two flops, third only for edges
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			meta_q <= '1;
			pin_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= scfe_pins_t'({cs_n_i, sclk_i, si_i, hold_n_i, wp_n_i});
			pin_q <= meta_q;
			prev_q <= pin_q;
		end
	end

	assign cs_fall = prev_q.cs_n & ~pin_q.cs_n;
	assign cs_rise = ~prev_q.cs_n & pin_q.cs_n;
	// Clock edges are masked while paused
	assign sck_rise = ~hold_q & ~pin_q.cs_n & ~prev_q.sclk & pin_q.sclk; // RULE_05 RULE_17
	assign sck_fall = ~hold_q & ~pin_q.cs_n & prev_q.sclk & ~pin_q.sclk; // RULE_05
	assign byte_done = sck_rise & (bit_cnt_q == BIT_LAST);
	assign nb = {shin_q[6:0], pin_q.si};
	assign ci = cmd_decode(nb);
	assign level = {st_q[SB_HI], st_q[SB_LO]};
	assign pin_guard = st_q[SB_GUARD] & ~pin_q.wp_n; // RULE_14

	always_comb begin
		stat_byte = st_q;
		stat_byte[SB_WEL] = wel_q;
		stat_byte[SB_BUSY] = busy_i;
	end
	assign src_byte = (info_q.kind == CK_STRD) ? stat_byte : rd_byte_i;

	// Pause follows the pin only while the clock is low, so a change
	// with the clock high waits for it to drop
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || pin_q.cs_n) begin
			hold_q <= 1'b0; // RULE_19
		end else if (!pin_q.sclk) begin
			hold_q <= ~pin_q.hold_n; // RULE_15 RULE_16
		end
	end

	// Command framing; state is kept as is while paused
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_q <= SS_IDLE; // RULE_09
			bit_cnt_q <= BIT_ZERO;
			byte_cnt_q <= NB_ZERO;
			shin_q <= '0;
			info_q <= '0;
			addr_q <= '0;
		end else if (cs_fall) begin
			state_q <= SS_CMD;
			bit_cnt_q <= BIT_ZERO;
			byte_cnt_q <= NB_ZERO;
		end else if (pin_q.cs_n) begin
			state_q <= SS_IDLE; // RULE_04
		end else if (sck_rise) begin
			shin_q <= nb;
			bit_cnt_q <= bit_cnt_q + BIT_ONE;
			if (bit_cnt_q == BIT_LAST) begin
				if (byte_cnt_q != NB_MAX) begin
					byte_cnt_q <= byte_cnt_q + NB_ONE;
				end
				unique case (state_q)
					SS_CMD: begin
						info_q <= ci;
						if (ci.kind == CK_NONE) begin
							state_q <= SS_IGNORE; // RULE_03
						end else if (sleep_q && ci.kind != CK_SIG) begin
							state_q <= SS_IGNORE; // RULE_12
						end else if (busy_i && is_array(ci.kind)) begin
							state_q <= SS_IGNORE; // RULE_08
						end else if (ci.addr) begin
							state_q <= SS_ADDR; // RULE_04
						end else begin
							state_q <= ci.out ? SS_OUT : SS_IN;
						end
					end
					SS_ADDR: begin
						addr_q <= {addr_q[ADDR_W-9:0], nb};
						if (byte_cnt_q == ADDR_LAST) begin
							if (info_q.dummy) begin
								state_q <= SS_DUMMY;
							end else begin
								state_q <= info_q.out ? SS_OUT : SS_IN;
							end
						end
					end
					SS_DUMMY: state_q <= SS_OUT;
					SS_IDLE, SS_IN, SS_OUT, SS_IGNORE: ;
				endcase
			end
		end
	end

	// Output path: prefetch on entry, then one byte ahead per load
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rd_req_q <= 1'b0;
			rd_q <= '0;
			in_out_q <= 1'b0;
			sh_q <= '0;
			obit_q <= BIT_ZERO;
			so_q <= 1'b0;
			sio0_q <= 1'b0;
		end else begin
			rd_req_q <= 1'b0;
			in_out_q <= state_q == SS_OUT;
			if (state_q == SS_OUT && !in_out_q) begin
				rd_req_q <= 1'b1;
				rd_q <= '{info_q.kind, addr_q};
				obit_q <= BIT_ZERO;
			end else if (state_q == SS_OUT && sck_fall) begin // RULE_06
				if (obit_q == BIT_ZERO) begin
					so_q <= src_byte[7];
					sio0_q <= src_byte[6];
					sh_q <= out_shift(src_byte, info_q.dual);
					rd_req_q <= 1'b1;
					rd_q.addr <= ADDR_W'(rd_q.addr + 1'b1);
				end else begin
					so_q <= sh_q[7];
					sio0_q <= sh_q[6];
					sh_q <= out_shift(sh_q, info_q.dual);
				end
				obit_q <= obit_q + (info_q.dual ? BIT_TWO : BIT_ONE);
			end
		end
	end

	// Drivers off in standby, while paused and outside data-out
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			so_oe_q <= 1'b0;
			si_oe_q <= 1'b0;
		end else begin
			so_oe_q <= state_q == SS_OUT && !hold_q && !pin_q.cs_n; // RULE_03 RULE_17
			si_oe_q <= state_q == SS_OUT && !hold_q && !pin_q.cs_n &&
				info_q.dual;
		end
	end

	always_comb begin
		len_ok = 1'b0;
		case (info_q.kind)
			CK_UNLOCK, CK_LOCK, CK_SLEEP, CK_CWIPE, CK_SIG:
				len_ok = byte_cnt_q == NB_ONE;
			CK_STWR: len_ok = byte_cnt_q == NB_STWR;
			CK_SWIPE, CK_BWIPE: len_ok = byte_cnt_q == NB_ADDR;
			CK_PAGE: len_ok = byte_cnt_q >= NB_PAGE;
			default: len_ok = 1'b0;
		endcase
		blocked = is_change(info_q.kind) && !wel_q; // RULE_10
		if (info_q.kind == CK_STWR && pin_guard) begin
			blocked = 1'b1; // RULE_14
		end
		if (info_q.kind inside {CK_PAGE, CK_SWIPE, CK_BWIPE} &&
			prot_hit(addr_q, level)) begin
			blocked = 1'b1; // RULE_21
		end
		if (info_q.kind == CK_CWIPE && level != PL_NONE) begin
			blocked = 1'b1; // RULE_13
		end
	end

	// Deselect during a pause executes nothing; mid-byte, only a signature readout releases sleep
	assign go = cs_rise & ~hold_q & (state_q != SS_IGNORE) &
		(bit_cnt_q == BIT_ZERO) & len_ok & ~blocked; // RULE_07 RULE_19
	assign push = (state_q == SS_IN) & (info_q.kind == CK_PAGE) &
		byte_done & ~blocked;

	// Busy only gates new accesses; ops in flight are never cut off
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wel_q <= 1'b0; // RULE_11
			sleep_q <= 1'b0;
			st_q <= ST_RST;
			op_valid_q <= 1'b0;
			op_q <= '0;
			flush_q <= 1'b0;
		end else begin
			op_valid_q <= 1'b0;
			flush_q <= cs_rise && info_q.kind == CK_PAGE && !go;
			if (go) begin
				case (info_q.kind)
					CK_UNLOCK: wel_q <= 1'b1; // RULE_10
					CK_LOCK: wel_q <= 1'b0; // RULE_11
					CK_SLEEP: sleep_q <= 1'b1;
					CK_SIG: sleep_q <= 1'b0; // RULE_12
					CK_STWR: st_q <= shin_q & ST_WR_MASK;
					default: ;
				endcase
				if (is_change(info_q.kind)) begin
					wel_q <= 1'b0; // RULE_11
					op_valid_q <= 1'b1; // RULE_18
					op_q.kind <= info_q.kind;
					op_q.addr <= addr_q;
					if (info_q.kind == CK_SWIPE) begin
						op_q.addr <= align(addr_q, SECT_LSB); // RULE_01
					end else if (info_q.kind == CK_BWIPE) begin
						op_q.addr <= align(addr_q, BLK_LSB); // RULE_02
					end
				end
			end
			// Signature readout also releases sleep, at any bit
			if (cs_rise && !hold_q && info_q.kind == CK_SIG &&
				state_q == SS_OUT) begin
				sleep_q <= 1'b0; // RULE_12
			end
		end
	end

	// A byte the full buffer cannot take is lost; the flag tells why
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			overrun_q <= 1'b0;
		end else if (push && !fifo_rdy) begin
			overrun_q <= 1'b1;
		end else if (cs_fall) begin
			overrun_q <= 1'b0;
		end
	end

	scfe_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.rst_i(sys_rst_i),
		.flush_i(flush_q),
		.in_valid_i(push),
		.in_ready_o(fifo_rdy),
		.in_data_i(nb),
		.out_valid_o(pg_valid_o),
		.out_ready_i(pg_ready_i),
		.out_data_o(pg_data_o)
	);

	assign so_o = so_q;
	assign so_oe_o = so_oe_q;
	assign si_o = sio0_q;
	assign si_oe_o = si_oe_q;
	assign op_valid_o = op_valid_q;
	assign op_o = op_q;
	assign rd_req_o = rd_req_q;
	assign rd_o = rd_q;
	assign pg_overrun_o = overrun_q;
	assign status_o = st_q;
	assign write_latch_flag_o = wel_q;
	assign sleep_o = sleep_q;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence bad_opcode_s;
		state_q == SS_CMD && byte_done && ci.kind == CK_NONE;
	endsequence
	sequence good_opcode_s;
		state_q == SS_CMD && byte_done && ci.kind != CK_NONE &&
			!sleep_q && !busy_i;
	endsequence
	sequence hold_req_s;
		!pin_q.cs_n && !pin_q.hold_n && !pin_q.sclk;
	endsequence

	reset_standby_a: assert property ($fell(sys_rst_i) |-> // RULE_09
		state_q == SS_IDLE && !wel_q && !sleep_q)
		else $error("state not standby after reset");
	bad_opcode_a: assert property (bad_opcode_s |=> // RULE_03
		state_q == SS_IGNORE ##1 !so_oe_q)
		else $error("unknown opcode not ignored");
	good_opcode_a: assert property (good_opcode_s |=> // RULE_04
		state_q inside {SS_ADDR, SS_IN, SS_OUT})
		else $error("valid opcode did not go active");
	busy_ignore_a: assert property (state_q == SS_CMD && byte_done && // RULE_08
		busy_i && is_array(ci.kind) |=> state_q == SS_IGNORE)
		else $error("array access taken while busy");
	byte_edge_a: assert property (op_valid_q |-> // RULE_07
		$past(bit_cnt_q) == BIT_ZERO && $past(cs_rise))
		else $error("command run off byte boundary");
	latch_need_a: assert property (op_valid_q |-> $past(wel_q)) // RULE_10
		else $error("change taken with latch clear");
	latch_clear_a: assert property (op_valid_q |-> !wel_q) // RULE_11
		else $error("latch not cleared after change");
	sleep_filter_a: assert property (op_valid_q |-> !$past(sleep_q)) // RULE_12
		else $error("change taken while sleeping");
	prot_area_a: assert property (op_valid_q && // RULE_21
		op_q.kind inside {CK_PAGE, CK_SWIPE, CK_BWIPE} |->
		!prot_hit($past(addr_q), level))
		else $error("protected area modified");
	pin_lock_a: assert property (!$stable(st_q) |-> // RULE_14
		!$past(pin_guard))
		else $error("status changed under pin guard");
	hold_start_a: assert property (hold_req_s |=> hold_q) // RULE_15
		else $error("pause did not start");
	hold_end_a: assert property (hold_q && pin_q.hold_n && // RULE_16
		!pin_q.sclk && !pin_q.cs_n |=> !hold_q)
		else $error("pause did not end");
	hold_freeze_a: assert property (hold_q && !pin_q.cs_n |=> // RULE_17
		!so_oe_q && $stable(state_q) && $stable(bit_cnt_q))
		else $error("paused interface not frozen");
endmodule
`default_nettype wire

/* File: dv/scfe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scfe_host
	import scfe_pkg::*;
(
	input wire logic mclk_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	input wire logic sio_i,
	input wire logic sio_oe_i,
	input wire logic wp_n_i,
	output var scfe_pins_t pins_o
);
	localparam int HALF = 8;
	logic cs_n = 1'b1;
	logic sclk = 1'b0;
	logic sd = 1'b0;
	logic hold_n = 1'b1;
	logic oe_in_pause = 1'b0;
	logic [7:0] rx_lo = 8'h00;
	assign pins_o = '{cs_n, sclk, sd, hold_n, wp_n_i};

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// Clock and data wiggle while paused to show they are ignored
	task automatic pause(input logic cut);
		hold_n = 1'b0;
		tick(HALF);
		repeat (4) begin
			sclk = ~sclk;
			sd = ~sd;
			if (so_oe_i !== 1'b0)
				oe_in_pause = 1'b1;
			tick(HALF);
		end
		if (cut) begin
			cs_n = 1'b1;
			tick(HALF);
		end
		hold_n = 1'b1;
		tick(HALF);
	endtask

	task automatic frame(input logic [111:0] tx, input int ntx, input int nrx,
		input logic cpol, input int pat, input logic cut,
		output logic [15:0] rx);
		rx = '0;
		sclk = cpol;
		tick(HALF);
		cs_n = 1'b0;
		tick(HALF);
		for (int i = 0; i < ntx + nrx; i++) begin
			sclk = 1'b0;
			sd = (i < ntx) ? tx[ntx-1-i] : ~sd;
			tick(HALF);
			if (i == pat)
				pause(cut);
			if (cut && i == pat)
				return;
			// Undriven output reads as inverse of last bit, never a lucky match
			if (i >= ntx) begin
				rx = {rx[14:0], so_oe_i ? so_i : ~rx[0]};
				rx_lo = {rx_lo[6:0], sio_oe_i ? sio_i : ~rx_lo[0]};
			end
			sclk = 1'b1;
			tick(HALF);
		end
		sclk = cpol;
		tick(HALF);
		cs_n = 1'b1;
		tick(HALF);
	endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import scfe_pkg::*;
;
	typedef struct packed {
		logic [111:0] tx;
		int n;
		int nrx;
		int op;
		scfe_kind_t k;
		logic [18:0] a;
		logic [5:0] fl;
		logic [7:0] st;
		logic [15:0] rx;
	} scfe_row_t;
	localparam int NR = 37;
	// Flags: unlock first, wp_n, busy, latch, sleep, output seen
	localparam scfe_row_t ROWS [NR] = '{
		'{112'h00c,9,0,0,CK_NONE,19'h0,6'h10,8'h00,16'h0},
		'{112'h06,8,0,2,CK_NONE,19'h0,6'h14,8'h00,16'h0},
		'{112'h2007f123,32,0,1,CK_SWIPE,19'h7f000,6'h10,8'h00,16'h0},
		'{112'h20010fff,32,0,0,CK_NONE,19'h0,6'h10,8'h00,16'h0},
		'{112'hd801abcd,32,0,1,CK_BWIPE,19'h10000,6'h30,8'h00,16'h0},
		'{112'h04,8,0,2,CK_NONE,19'h0,6'h30,8'h00,16'h0},
		'{112'h020123455a,40,0,1,CK_PAGE,19'h12345,6'h30,8'h00,16'h0},
		'{112'h1003f8918,35,0,0,CK_NONE,19'h0,6'h34,8'h00,16'h0},
		'{112'h0108,16,0,1,CK_STWR,19'h0,6'h10,8'h08,16'h0},
		'{112'h20020000,32,0,0,CK_NONE,19'h0,6'h34,8'h08,16'h0},
		'{112'h20010000,32,0,1,CK_SWIPE,19'h10000,6'h10,8'h08,16'h0},
		'{112'h0104,16,0,1,CK_STWR,19'h0,6'h30,8'h04,16'h0},
		'{112'h20030000,32,0,0,CK_NONE,19'h0,6'h34,8'h04,16'h0},
		'{112'h20020000,32,0,1,CK_SWIPE,19'h20000,6'h10,8'h04,16'h0},
		'{112'h010c,16,0,1,CK_STWR,19'h0,6'h30,8'h0c,16'h0},
		'{112'h60,8,0,0,CK_NONE,19'h0,6'h34,8'h0c,16'h0},
		'{112'h0100,16,0,1,CK_STWR,19'h0,6'h10,8'h00,16'h0},
		'{112'h60,8,0,1,CK_CWIPE,19'h0,6'h30,8'h00,16'h0},
		'{112'h20010000,32,0,0,CK_NONE,19'h0,6'h3c,8'h00,16'h0},
		'{112'h03000000,32,8,0,CK_NONE,19'h0,6'h1c,8'h00,16'h00aa},
		'{112'h04,8,0,2,CK_NONE,19'h0,6'h10,8'h00,16'h0},
		'{112'h0188,16,0,1,CK_STWR,19'h0,6'h30,8'h88,16'h0},
		'{112'h0100,16,0,0,CK_NONE,19'h0,6'h24,8'h88,16'h0},
		'{112'h0100,16,0,1,CK_STWR,19'h0,6'h10,8'h00,16'h0},
		'{112'h03012345,32,16,0,CK_NONE,19'h0,6'h11,8'h00,16'h797a},
		'{112'h0b00010000,40,8,0,CK_NONE,19'h0,6'h11,8'h00,16'h003c},
		'{112'h9f,8,0,0,CK_NONE,19'h0,6'h11,8'h00,16'h0},
		'{112'h5a00000000,40,0,0,CK_NONE,19'h0,6'h11,8'h00,16'h0},
		'{112'h3b00000000,40,0,0,CK_NONE,19'h0,6'h11,8'h00,16'h0},
		'{112'h90000000,32,0,0,CK_NONE,19'h0,6'h11,8'h00,16'h0},
		'{112'hab000000,32,0,0,CK_NONE,19'h0,6'h11,8'h00,16'h0},
		'{112'h05,8,8,0,CK_NONE,19'h0,6'h11,8'h00,16'h0000},
		'{112'hff00000000,40,8,0,CK_NONE,19'h0,6'h10,8'h00,16'h00aa},
		'{112'hb9,8,0,2,CK_NONE,19'h0,6'h12,8'h00,16'h0},
		'{112'h06,8,0,2,CK_NONE,19'h0,6'h12,8'h00,16'h0},
		'{112'h05,8,8,0,CK_NONE,19'h0,6'h12,8'h00,16'h00aa},
		'{112'hab,8,0,2,CK_NONE,19'h0,6'h10,8'h00,16'h0}
	};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic busy = 1'b0;
	logic wp_n = 1'b1;
	logic pg_ready = 1'b1;
	logic [7:0] rd_byte = 8'h00;
	logic si_o, si_oe, so, so_oe, op_valid, rd_req;
	logic pg_valid, pg_overrun, write_latch_flag, slp;
	logic [7:0] pg_data, status, pg_last;
	scfe_pins_t pins;
	scfe_op_t op, rd;
	int error_cnt = 0;
	int samples_checked = 0;
	int op_cnt = 0;
	int oe_cnt = 0;
	int pg_cnt = 0;
	int o0, e0, p0;
	logic [15:0] rx;
	scfe_row_t r;

	scfe_front #(.FIFO_DEPTH(8)) scfe_front_inst (
		.mclk_i(mclk), .sys_rst_i(rst), .cs_n_i(pins.cs_n),
		.sclk_i(pins.sclk), .si_i(si_oe === 1'b1 ? si_o : pins.si),
		.hold_n_i(pins.hold_n), .wp_n_i(pins.wp_n), .si_o(si_o),
		.si_oe_o(si_oe), .so_o(so), .so_oe_o(so_oe), .busy_i(busy),
		.op_valid_o(op_valid), .op_o(op), .rd_req_o(rd_req), .rd_o(rd),
		.rd_byte_i(rd_byte), .pg_valid_o(pg_valid), .pg_data_o(pg_data),
		.pg_ready_i(pg_ready), .pg_overrun_o(pg_overrun),
		.status_o(status), .write_latch_flag_o(write_latch_flag), .sleep_o(slp)
	);
	scfe_host scfe_host_inst (.mclk_i(mclk), .so_i(so), .so_oe_i(so_oe),
		.sio_i(si_o), .sio_oe_i(si_oe), .wp_n_i(wp_n), .pins_o(pins));

	initial forever #5 mclk = ~mclk;

	always @(posedge mclk) begin
		if (op_valid === 1'b1)
			op_cnt++;
		if (so_oe === 1'b1)
			oe_cnt++;
		if (pg_valid === 1'b1 && pg_ready) begin
			pg_cnt++;
			pg_last = pg_data;
		end
	end

	always @(negedge mclk)
		if (rd_req === 1'b1)
			rd_byte <= rd.addr[7:0] ^ 8'h3c;

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic go(input logic [111:0] tx, input int n, input int nrx);
		scfe_host_inst.frame(tx, n, nrx, 1'b0, -1, 1'b0, rx);
		repeat (4) @(negedge mclk);
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		chk_flag(1'b1, 1'b0);
		conclude();
	end

	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (6) @(negedge mclk);
		for (int i = 0; i < NR; i++) begin
			r = ROWS[i];
			wp_n = r.fl[4];
			busy = r.fl[3];
			if (r.fl[5])
				go(112'h06, 8, 0);
			o0 = op_cnt;
			e0 = oe_cnt;
			go(r.tx, r.n, r.nrx);
			if (r.op != 2)
				chk_val(op_cnt - o0, r.op);
			if (r.op == 1)
				chk_val(op.kind, r.k);
			if (r.op == 1 && !(r.k inside {CK_CWIPE, CK_STWR}))
				chk_val(op.addr, r.a);
			chk_flag(write_latch_flag, r.fl[2]);
			chk_val(status & 8'h8c, r.st);
			chk_flag(slp, r.fl[1]);
			chk_flag(oe_cnt != e0, r.fl[0]);
			chk_val(rx, r.rx);
			$display("row %0d done", i);
		end
		go(112'h06, 8, 0);
		scfe_host_inst.frame(112'h05, 8, 8, 1'b0, 11, 1'b0, rx);
		chk_val(rx, 16'h0002);
		chk_flag(scfe_host_inst.oe_in_pause, 1'b0);
		$display("pause done");
		scfe_host_inst.frame(112'h0108, 16, 0, 1'b0, 12, 1'b1, rx);
		repeat (4) @(negedge mclk);
		chk_val(status & 8'h8c, 8'h00);
		go(112'h0108, 16, 0);
		chk_val(status & 8'h8c, 8'h08);
		$display("cut pause done");
		scfe_host_inst.frame(112'h03000010, 32, 16, 1'b1, -1, 1'b0, rx);
		chk_val(rx, 16'h2c2d);
		$display("mode 3 done");
		scfe_host_inst.frame(112'h3b00001000, 40, 8, 1'b0, -1, 1'b0, rx);
		chk_val(rx, 16'h0066);
		chk_val({24'h0, scfe_host_inst.rx_lo}, 32'h23);
		$display("dual done");
		pg_ready = 1'b0;
		p0 = pg_cnt;
		go(112'h06, 8, 0);
		go({32'h02000100, 80'h11223344556677889900}, 112, 0);
		chk_flag(pg_overrun, 1'b1);
		pg_ready = 1'b1;
		repeat (40) @(negedge mclk);
		chk_val(pg_cnt - p0, 9);
		chk_val({24'h0, pg_last}, 32'h99);
		chk_flag(pg_valid, 1'b0);
		$display("fifo done");
		go(112'h06, 8, 0);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		chk_flag(write_latch_flag, 1'b0);
		chk_val({24'h0, status}, 32'h0);
		chk_flag(so_oe, 1'b0);
		$display("reset done");
		conclude();
	end
endmodule
`default_nettype wire
